/* File: rtl/vic_consts.vh */
// constants for the vectored interrupt controller register block
// What this block does
// - mask readback: bit per source, 1 means enabled, bit0 fast, bit1 system
// - core status: bit0 live fast line, bit1 live normal line
// - writing 1 to enable command sets that source's enable
// - writing 1 to disable command clears enable, source cannot request
// - writing 1 to clear command removes the source's pending state
// - writing 1 to set command makes the source pending by software
// - any write to end-of-interrupt register signals handler completion
// - spurious vector holds 32-bit value returned on spurious vector reads
// - debug control bit 0 selects protection mode
// - debug control bit 1 general mask holds both core lines inactive
// - writing 1 to fast-force enable bits 1..31 turns forcing on
// - writing 1 to fast-force disable bits 1..31 turns forcing off
// - fast-force status reads forcing state, bit 0 reserved zero
// - normal vector read returns vector of highest priority enabled pending normal source, else spurious vector
// - each non-fast source has priority 0 lowest to 7 highest
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define VIC_SVR_BASE      12'h080
`define VIC_PRIO_BASE     12'h000
`define VIC_NVEC_OFF      12'h100
`define VIC_FVEC_OFF      12'h104
`define VIC_CUR_OFF       12'h108
`define VIC_PEND_OFF      12'h10C
`define VIC_MASK_OFF      12'h110
`define VIC_CORE_OFF      12'h114
`define VIC_IEN_OFF       12'h120
`define VIC_IDIS_OFF      12'h124
`define VIC_ICLR_OFF      12'h128
`define VIC_ISET_OFF      12'h12C
`define VIC_EOI_OFF       12'h130
`define VIC_SPU_OFF       12'h134
`define VIC_DBG_OFF       12'h138
`define VIC_FFEN_OFF      12'h140
`define VIC_FFDIS_OFF     12'h144
`define VIC_FFST_OFF      12'h148
`define VIC_EVST_OFF      12'h150
`define VIC_EVMSK_OFF     12'h154
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define VIC_DBG_PROTECTION_MODE_BIT  0
`define VIC_DBG_GENERAL_LINE_MASK_BIT  1
`define VIC_CORE_FAST_BIT 0
`define VIC_CORE_NORM_BIT 1
`define VIC_EV_EOI_BIT    0
`define VIC_EV_SPUR_BIT   1
`define VIC_RST_WORD      32'h0000_0000
`define VIC_FF_VALID      32'hFFFF_FFFE
`define VIC_RESP_OKAY     2'b00
`define VIC_RESP_SLVERR   2'b10
`endif

/* File: rtl/vic_regs.v */
// vectored interrupt controller register block with AXI4-Lite slave
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_regs #(
   parameter NSRC = 32
) (
   // clock, reset, enable
   input  wire        sys_clk_i,
   input  wire        rst_n_i,
   input  wire        clk_en_i,
   // interrupt sources, level high
   input  wire [31:0] src_irq_i,
   // axi4-lite write address and data
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // core request lines, active high toward the core
   output reg         fast_req_o,
   output reg         norm_req_o,
   // controller status
   output reg         protection_mode_o,
   output reg         eoi_pulse_o,
   output reg         irq_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg  [31:0] enable_r;
   reg  [31:0] pend_r;
   reg  [31:0] ffen_r;
   reg  [31:0] spu_r;
   reg  [1:0]  dbg_r;
   reg  [31:0] vec_r [0:NSRC-1];
   reg  [2:0]  prio_r [0:NSRC-1];
   reg         cur_act_r;
   reg  [4:0]  cur_id_r;
   reg  [1:0]  evst_r;
   reg  [1:0]  evmsk_r;
   reg  [11:0] awaddr_r;
   reg  [31:0] wdata_r;
   reg         aw_have_r;
   reg         w_have_r;
   reg  [31:0] src_q_r;

   wire        wr_go   = aw_have_r & w_have_r & ~s_axi_bvalid;
   wire        rd_go   = s_axi_arvalid & s_axi_arready;
   wire [11:0] ra      = s_axi_araddr;
   wire [31:0] wmask   = wr_go ? wdata_r : 32'h0000_0000;
   wire        wr_en   = wr_go & (awaddr_r == `VIC_IEN_OFF);
   wire        wr_dis  = wr_go & (awaddr_r == `VIC_IDIS_OFF);
   wire        wr_clr  = wr_go & (awaddr_r == `VIC_ICLR_OFF);
   wire        wr_set  = wr_go & (awaddr_r == `VIC_ISET_OFF);
   wire        wr_eoi  = wr_go & (awaddr_r == `VIC_EOI_OFF);
   wire        wr_ffe  = wr_go & (awaddr_r == `VIC_FFEN_OFF);
   wire        wr_ffd  = wr_go & (awaddr_r == `VIC_FFDIS_OFF);
   wire        rd_nvec = rd_go & (ra == `VIC_NVEC_OFF);
   wire        rd_fvec = rd_go & (ra == `VIC_FVEC_OFF);

   // ---------------------------------------------------------------
   // request resolution
   // ---------------------------------------------------------------
   wire [31:0] active  = pend_r & enable_r;
   wire [31:0] to_fast = active & ((ffen_r & `VIC_FF_VALID)
                                   | 32'h0000_0001);
   wire [31:0] to_norm = active & ~to_fast;
   wire        fast_nxt = |to_fast & ~dbg_r[`VIC_DBG_GENERAL_LINE_MASK_BIT];
   wire        norm_nxt = |to_norm & ~dbg_r[`VIC_DBG_GENERAL_LINE_MASK_BIT];

   // highest priority normal source; lower number wins a tie
   reg  [4:0]  best_id;
   reg  [2:0]  best_pr;
   reg         best_ok;
   integer     k;
   always @* begin
      best_id = 5'h00;
      best_pr = 3'h0;
      best_ok = 1'b0;
      for (k = NSRC - 1; k >= 0; k = k - 1) begin
         if (to_norm[k] && (!best_ok || prio_r[k] >= best_pr)) begin
            best_ok = 1'b1;
            best_pr = prio_r[k];
            best_id = k[4:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // axi write channel capture
   // ---------------------------------------------------------------
   // address and data taken in either order, response once both held
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= 12'h000;
         wdata_r       <= 32'h0000_0000;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `VIC_RESP_OKAY;
      end else if (clk_en_i) begin
         s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known(awaddr_r) ? `VIC_RESP_OKAY
                                               : `VIC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // writable or command offset check
   function wr_known;
      input [11:0] a;
      begin
         wr_known = (a < 12'h100) || a == `VIC_IEN_OFF ||
            a == `VIC_IDIS_OFF || a == `VIC_ICLR_OFF ||
            a == `VIC_ISET_OFF || a == `VIC_EOI_OFF ||
            a == `VIC_SPU_OFF || a == `VIC_DBG_OFF ||
            a == `VIC_FFEN_OFF || a == `VIC_FFDIS_OFF ||
            a == `VIC_EVST_OFF || a == `VIC_EVMSK_OFF;
      end
   endfunction

   // ---------------------------------------------------------------
   // per-source priority and vector tables
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : g_src
         always @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               prio_r[g] <= 3'h0;
               vec_r[g]  <= `VIC_RST_WORD;
            end else if (clk_en_i && wr_go) begin
               if (awaddr_r == `VIC_PRIO_BASE + g * 4)
                  prio_r[g] <= wdata_r[2:0];
               if (awaddr_r == `VIC_SVR_BASE + g * 4)
                  vec_r[g] <= wdata_r;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // source state: enable, pending, fast forcing, config
   // ---------------------------------------------------------------
   // sources set pending only on a registered rising edge, so short
   // pulses are not lost; a level still high re-arms it on acknowledge
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enable_r <= 32'h0000_0000;
         pend_r   <= 32'h0000_0000;
         ffen_r   <= 32'h0000_0000;
         spu_r    <= `VIC_RST_WORD;
         dbg_r    <= 2'b00;
         src_q_r  <= 32'h0000_0000;
         evmsk_r  <= 2'b00;
      end else if (clk_en_i) begin
         src_q_r <= src_irq_i;
         // zero bits leave the other sources as they were
         enable_r <= (enable_r | (wr_en ? wmask : 32'h0))
                     & ~(wr_dis ? wmask : 32'h0);
         // hardware set wins over a software clear in the same cycle
         pend_r <= (pend_r & ~(wr_clr ? wmask : 32'h0))
                   | (wr_set ? wmask : 32'h0)
                   | (src_irq_i & ~src_q_r);
         ffen_r <= ((ffen_r | (wr_ffe ? wmask : 32'h0))
                    & ~(wr_ffd ? wmask : 32'h0))
                   & `VIC_FF_VALID;
         if (wr_go && awaddr_r == `VIC_SPU_OFF)
            spu_r <= wdata_r;
         if (wr_go && awaddr_r == `VIC_DBG_OFF)
            dbg_r <= wdata_r[1:0];
         if (wr_go && awaddr_r == `VIC_EVMSK_OFF)
            evmsk_r <= wdata_r[1:0];
         // reading the normal vector acknowledges the source it returns; a level
         // still high re-arms it at once so it is not lost
         if (rd_nvec && best_ok && !dbg_r[`VIC_DBG_PROTECTION_MODE_BIT])
            pend_r[best_id] <= src_irq_i[best_id];
      end
   end

   // ---------------------------------------------------------------
   // current interrupt tracking
   // ---------------------------------------------------------------
   // protection mode stops reads from changing pending and current state, so a debugger
   // can inspect vectors without disturbing the handler
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cur_act_r   <= 1'b0;
         cur_id_r    <= 5'h00;
         eoi_pulse_o <= 1'b0;
      end else if (clk_en_i) begin
         eoi_pulse_o <= wr_eoi;
         if (wr_eoi)
            cur_act_r <= 1'b0;
         else if (rd_nvec && !dbg_r[`VIC_DBG_PROTECTION_MODE_BIT]) begin
            cur_act_r <= best_ok;
            cur_id_r  <= best_id;
         end
      end
   end

   // ---------------------------------------------------------------
   // event status, mask and interrupt output
   // ---------------------------------------------------------------
   wire        spur_ev = (rd_nvec & ~best_ok) | (rd_fvec & ~to_fast[0]);
   wire [1:0]  ev_set  = {spur_ev, wr_eoi};
   wire        evc     = wr_go & (awaddr_r == `VIC_EVST_OFF);
   wire [1:0]  ev_nxt  = (evst_r & ~(evc ? wdata_r[1:0] : 2'b00)) | ev_set;
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evst_r            <= 2'b00;
         irq_o             <= 1'b0;
         fast_req_o        <= 1'b0;
         norm_req_o        <= 1'b0;
         protection_mode_o <= 1'b0;
      end else if (clk_en_i) begin
         evst_r            <= ev_nxt;                    // set wins over clear
         irq_o             <= |(ev_nxt & evmsk_r);
         fast_req_o        <= fast_nxt;
         norm_req_o        <= norm_nxt;
         protection_mode_o <= dbg_r[`VIC_DBG_PROTECTION_MODE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // axi read channel
   // ---------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `VIC_RESP_OKAY;
      end else if (clk_en_i) begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `VIC_RESP_OKAY;
            case (ra)
               `VIC_NVEC_OFF:
                  s_axi_rdata <= best_ok ? vec_r[best_id] : spu_r;
               `VIC_FVEC_OFF:
                  s_axi_rdata <= to_fast[0] ? vec_r[0] : spu_r;
               `VIC_CUR_OFF:  s_axi_rdata <= {27'h0, cur_id_r};
               `VIC_PEND_OFF: s_axi_rdata <= pend_r;
               `VIC_MASK_OFF: s_axi_rdata <= enable_r;
               `VIC_CORE_OFF:
                  s_axi_rdata <= {30'h0, norm_req_o, fast_req_o};
               `VIC_SPU_OFF:  s_axi_rdata <= spu_r;
               `VIC_DBG_OFF:  s_axi_rdata <= {30'h0, dbg_r};
               `VIC_FFST_OFF: s_axi_rdata <= ffen_r;
               `VIC_EVST_OFF: s_axi_rdata <= {30'h0, evst_r};
               `VIC_EVMSK_OFF: s_axi_rdata <= {30'h0, evmsk_r};
               default: begin
                  if (ra < 12'h080 && ra[1:0] == 2'b00)
                     s_axi_rdata <= {29'h0, prio_r[ra[6:2]]};
                  else if (ra < 12'h100 && ra[1:0] == 2'b00)
                     s_axi_rdata <= vec_r[ra[6:2]];
                  else begin
                     s_axi_rdata <= 32'h0000_0000;
                     s_axi_rresp <= `VIC_RESP_SLVERR;
                  end
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // vic_regs

/* File: testbench/vic_core_model.sv */
// core side model: records which request line went active
`timescale 1ns/1ps
module vic_core_model (
   // clock and reset
   input  wire sys_clk_i,
   input  wire rst_n_i,
   // request levels and flag clear
   input  wire fast_req_i,
   input  wire norm_req_i,
   input  wire clr_i,
   // lines seen active since the last clear
   output reg  fast_seen_o,
   output reg  norm_seen_o
);
   // a core only samples levels, so sticky flags keep short bursts
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fast_seen_o <= 1'b0;
         norm_seen_o <= 1'b0;
      end else begin
         fast_seen_o <= !clr_i && (fast_seen_o || fast_req_i);
         norm_seen_o <= !clr_i && (norm_seen_o || norm_req_i);
      end
   end
endmodule // vic_core_model

/* File: testbench/vic_regs_monitor.sv */
// assertion checker for the interrupt controller register block
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_regs_monitor (
   // clock and reset
   input wire        sys_clk_i,
   input wire        rst_n_i,
   // register bus
   input wire [11:0] s_axi_awaddr,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // core lines and status
   input wire        fast_req_o,
   input wire        norm_req_o,
   input wire        protection_mode_o,
   input wire        eoi_pulse_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   reg [11:0] wa_r;
   reg [31:0] wd_r;
   reg        bv_r;
   reg        gm_r;
   reg        pm_r;
   // shadow of the debug control word, taken when the response rises
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wa_r <= 12'h000;
         wd_r <= 32'h0000_0000;
         bv_r <= 1'b0;
         gm_r <= 1'b0;
         pm_r <= 1'b0;
      end else begin
         bv_r <= s_axi_bvalid;
         if (s_axi_awready) wa_r <= s_axi_awaddr;
         if (s_axi_wready) wd_r <= s_axi_wdata;
         if (s_axi_bvalid && !bv_r && wa_r == `VIC_DBG_OFF) begin
            gm_r <= wd_r[`VIC_DBG_GENERAL_LINE_MASK_BIT];
            pm_r <= wd_r[`VIC_DBG_PROTECTION_MODE_BIT];
         end
      end
   end
   a_gmask_lines: assert property (gm_r && $past(gm_r) |->
      !fast_req_o && !norm_req_o) else $error("lines active under mask");
   a_protection_mode_mirror: assert property (pm_r == $past(pm_r) |->
      protection_mode_o == pm_r) else $error("protection mirror wrong");
   a_eoi_single: assert property (eoi_pulse_o |=> !eoi_pulse_o)
      else $error("end of irq pulse too long");
   a_eoi_cause: assert property (eoi_pulse_o |->
      wa_r == `VIC_EOI_OFF && (s_axi_bvalid || $past(s_axi_bvalid) ||
      $past(s_axi_bvalid, 2))) else $error("end of irq without write");
   a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response not released");
   a_rresp_drop: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read response not released");
   a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   a_no_new_aw: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while response pending");
   c_eoi: cover property (eoi_pulse_o);
   c_fast: cover property (fast_req_o);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp[1]);
endmodule // vic_regs_monitor

bind vic_regs vic_regs_monitor mon (.sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .fast_req_o(fast_req_o), .norm_req_o(norm_req_o),
   .protection_mode_o(protection_mode_o), .eoi_pulse_o(eoi_pulse_o));

/* File: testbench/vic_regs_tb.sv */
// self-checking bench for the interrupt controller register block
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_regs_tb;
   reg         sys_clk_i = 1'b0;
   reg         rst_n_i = 1'b0;
   reg  [31:0] src = 32'h0000_0000;
   reg  [11:0] awaddr = 12'h000;
   reg  [11:0] araddr = 12'h000;
   reg  [31:0] wdata = 32'h0000_0000;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   reg         arvalid = 1'b0, rready = 1'b0, clr = 1'b0, eoi_seen = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid;
   wire        fast, norm, protection_mode, eoi, irq, f_seen, n_seen;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   reg  [1:0]  resp;
   reg  [31:0] rd;
   integer     fails = 0, comparisons = 0, cyc = 0;

   vic_regs DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
      .src_irq_i(src), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .fast_req_o(fast), .norm_req_o(norm),
      .protection_mode_o(protection_mode), .eoi_pulse_o(eoi), .irq_o(irq));
   vic_core_model core_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .fast_req_i(fast), .norm_req_i(norm), .clr_i(clr),
      .fast_seen_o(f_seen), .norm_seen_o(n_seen));

   always #12.5 sys_clk_i = ~sys_clk_i;
   // the end of irq pulse lasts one cycle, so latch it for later checks
   always @(posedge sys_clk_i) if (eoi) eoi_seen <= 1'b1;
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge sys_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 8000) begin
         fails = fails + 1;
         $display("Error at %0t: timeout", $time);
         wrap_up;
      end
   end

   task wrap_up;
      begin
         $display("comparisons %0d, fails %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [31:0] e, input [31:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("Error at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task chk_resp(input [1:0] e, input [1:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("Error at %0t: resp %b want %b", $time, g, e);
         end
      end
   endtask
   // address and data offered together, each dropped when taken
   task wr(input [11:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge sys_clk_i);
            n = n + 1;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while (!bvalid && n < 40);
         resp = bresp;
         bready <= 1'b0;
         @(posedge sys_clk_i);
         chk_resp(`VIC_RESP_OKAY, resp);
      end
   endtask
   task rdr(input [11:0] a);
      integer n;
      begin
         n = 0;
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do begin
            @(posedge sys_clk_i);
            n = n + 1;
            if (arready) arvalid <= 1'b0;
         end while (!rvalid && n < 40);
         rd = rdata;
         resp = rresp;
         rready <= 1'b0;
         @(posedge sys_clk_i);
      end
   endtask
   task rchk(input [11:0] a, input [31:0] e);
      begin
         rdr(a);
         chk_resp(`VIC_RESP_OKAY, resp);
         chk(e, rd);
      end
   endtask

   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      // ---------------------------------------------------------------
      // reset values and an unmapped address
      // ---------------------------------------------------------------
      rchk(`VIC_MASK_OFF, 32'h0);
      rchk(`VIC_CORE_OFF, 32'h0);
      rchk(`VIC_FFST_OFF, 32'h0);
      rchk(`VIC_SPU_OFF, 32'h0);
      rchk(`VIC_DBG_OFF, 32'h0);
      rdr(12'h118);
      chk_resp(`VIC_RESP_SLVERR, resp);
      chk(32'h0, rd);
      $display("test reset values done");
      // enable and disable, zero bits leave others alone
      wr(`VIC_IEN_OFF, 32'h6);
      rchk(`VIC_MASK_OFF, 32'h6);
      wr(`VIC_IEN_OFF, 32'h8);
      rchk(`VIC_MASK_OFF, 32'hE);
      wr(`VIC_IDIS_OFF, 32'h2);
      rchk(`VIC_MASK_OFF, 32'hC);
      // software pending drives the normal line
      wr(`VIC_ISET_OFF, 32'h4);
      rchk(`VIC_PEND_OFF, 32'h4);
      rchk(`VIC_CORE_OFF, 32'h2);
      chk({30'h0, n_seen, f_seen}, 32'h2);
      wr(`VIC_IDIS_OFF, 32'h4);
      rchk(`VIC_CORE_OFF, 32'h0);
      wr(`VIC_ICLR_OFF, 32'h4);
      rchk(`VIC_PEND_OFF, 32'h0);
      $display("test enable and pending done");
      // ---------------------------------------------------------------
      // fast forcing
      // ---------------------------------------------------------------
      clr <= 1'b1;
      wr(`VIC_FFEN_OFF, 32'hFFFF_FFFF);
      clr <= 1'b0;
      rchk(`VIC_FFST_OFF, 32'hFFFF_FFFE);
      wr(`VIC_FFDIS_OFF, 32'h1);
      rchk(`VIC_FFST_OFF, 32'hFFFF_FFFE);
      wr(`VIC_IEN_OFF, 32'h4);
      wr(`VIC_ISET_OFF, 32'h4);
      rchk(`VIC_CORE_OFF, 32'h1);
      chk({30'h0, n_seen, f_seen}, 32'h1);
      wr(`VIC_FFDIS_OFF, 32'hFFFF_FFFE);
      rchk(`VIC_FFST_OFF, 32'h0);
      rchk(`VIC_CORE_OFF, 32'h2);
      $display("test fast forcing done");
      // general mask and protection mode
      wr(`VIC_DBG_OFF, 32'h2);
      rchk(`VIC_CORE_OFF, 32'h0);
      chk({30'h0, norm, fast}, 32'h0);
      wr(`VIC_DBG_OFF, 32'h1);
      rchk(`VIC_CORE_OFF, 32'h2);
      rchk(`VIC_DBG_OFF, 32'h1);
      chk({31'h0, protection_mode}, 32'h1);
      wr(`VIC_DBG_OFF, 32'h0);
      $display("test debug control done");
      // ---------------------------------------------------------------
      // vectors, priority, end of irq and event interrupt
      // ---------------------------------------------------------------
      wr(`VIC_ICLR_OFF, 32'hFFFF_FFFF);
      wr(`VIC_IDIS_OFF, 32'hFFFF_FFFF);
      wr(`VIC_SPU_OFF, 32'hC0DE_0123);
      rchk(`VIC_NVEC_OFF, 32'hC0DE_0123);
      rchk(`VIC_FVEC_OFF, 32'hC0DE_0123);
      wr(12'h08C, 32'h1234_5678);
      wr(12'h094, 32'h55AA_0005);
      wr(12'h014, 32'h7);
      wr(`VIC_IEN_OFF, 32'h28);
      wr(`VIC_ISET_OFF, 32'h28);
      rchk(`VIC_NVEC_OFF, 32'h55AA_0005);
      // the read acknowledged source 5 only; source 3 stays pending
      rchk(`VIC_PEND_OFF, 32'h8);
      rchk(`VIC_CUR_OFF, 32'h5);
      wr(`VIC_EOI_OFF, 32'hFFFF_FFFF);
      wr(`VIC_EVMSK_OFF, 32'h0);
      chk({31'h0, eoi_seen}, 32'h1);
      rchk(`VIC_EVST_OFF, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(`VIC_EVMSK_OFF, 32'h1);
      rchk(`VIC_EVMSK_OFF, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(`VIC_EVST_OFF, 32'h1);
      rchk(`VIC_EVST_OFF, 32'h2);
      chk({31'h0, irq}, 32'h0);
      $display("test vectors and events done");
      wrap_up;
   end
endmodule // vic_regs_tb
